// file: core/serial_port_regs.svh
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// register indices, byte address is four times the index
`define MODULE_STOP_IDX   20'h80014
`define SYS_CLK_IDX       20'h80020
`define RX_FULL_FLAG_IDX  20'h870d7
`define TX_EMPTY_FLAG_IDX 20'h870d8
`define IRQ_EN_A_IDX      20'h8721a
`define IRQ_EN_B_IDX      20'h8721b
`define IRQ_PRIO_IDX      20'h87380
`define MODE_IDX          20'h88240
`define DIVISOR_IDX       20'h88241
`define CONTROL_IDX       20'h88242
`define TX_DATA_IDX       20'h88243
`define STATUS_IDX        20'h88244
`define RX_DATA_IDX       20'h88245
`define IF_MODE_IDX       20'h88246
`define RX_BUF_IDX        20'h8c06b

// field positions
`define STOP_BIT      31
`define PCLK_SEL_MSB  11
`define PCLK_SEL_LSB  8
`define SCLK_SEL_MSB  27
`define SCLK_SEL_LSB  24
`define CTL_TX_IE     7
`define CTL_RX_IE     6
`define CTL_TX_EN     5
`define CTL_RX_EN     4
`define CTL_END_IE    2
`define CTL_CKE_MSB   1
`define CTL_CKE_LSB   0
`define MODE_CKS_MSB  1
`define MODE_CKS_LSB  0
`define STAT_TX_END   2
`define STAT_FRAME    4
`define STAT_OVERRUN  5
`define IFM_ORDER     3
`define IEN_A_RX      7
`define IEN_B_TX      0
`define RX_BUF_BIT    1

// reset values
`define DIVISOR_RST   8'hff
`define PCLK_SEL_RST  4'h1
`define SCLK_SEL_RST  4'h0
`define STOP_RST      1'b1

// timing: sixteen sub-ticks a bit, two pclk per sub-tick at divisor 0
`define SUBTICK_SHIFT 1
`define RX_MID        4'h7
`define TICK_LAST     4'hf

`endif

// file: core/serial_port_pkg.sv
package serial_port_pkg;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  typedef struct packed {
    logic [21:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_s;

  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
    logic        mstp;
    logic [3:0]  periph_clock_select;
    logic [3:0]  system_clock_select;
    logic        rxbuf;
    logic [7:0]  mode;
    logic [7:0]  div;
    logic [7:0]  ctl;
    logic [7:0]  tdr;
    logic [7:0]  rdr;
    logic [7:0]  ifm;
    logic [3:0]  prio;
    logic        ien_rx;
    logic        ien_tx;
    logic        ir_rx;
    logic        ir_tx;
    logic        framing_error_flag;
    logic        overrun_error_flag;
    logic        tdr_full;
    logic [2:0]  pcnt;
    logic [15:0] scnt;
    tx_state_e   tx_st;
    logic [7:0]  tx_sh;
    logic [2:0]  tx_bit;
    logic [3:0]  tx_tk;
    logic        txd;
    rx_state_e   rx_st;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bit;
    logic [3:0]  rx_tk;
    logic        sclk;
    logic        sclk_oe_n;
    logic [3:0]  irq;
  } state_s;

endpackage

// file: core/serial_port.sv
`timescale 1ns/1ps
`include "serial_port_regs.svh"

// Summary of operation
// [RULE1] clock enable 00: internal baud, pin released
// [RULE2] clock enable writable only when disabled
// [RULE3] enables set from idle; both clear together
// [RULE4] control bits gate the four requests
// [RULE5] mode zero: pclk, no multiproc, 1 stop, no parity
// [RULE6] mode zero: 8-bit characters, asynchronous
// [RULE7] mode and interface writes only when disabled
// [RULE8] interface zero: plain serial, lsb first
// [RULE9] divisor 31h at 50 MHz gives 31250 bps
// [RULE10] divisor always readable, written only when disabled
// [RULE11] tx end reads 0 sending, 1 finished
// [RULE12] framing error sets status bit 4
// [RULE13] overrun sets status bit 5
// [RULE14] error flags cleared only by writing 0
// [RULE15] tx data holds byte; rx data read-only
// [RULE16] priority zero blocks every channel request
// [RULE17] enable bytes gate rx full, tx empty
// [RULE18] request flags pending high, cleared by 0
// [RULE19] module stop clear lets channel run
// [RULE20] clock selects: pclk x4, system x8
// [RULE21] rx pin buffer bit passes serial input
// [RULE22] software waits one bit after divisor write
// [RULE23] flags set on rx load, tx free
module serial_port (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire serial_port_pkg::bus_req_s avs_req_i,
  output logic [31:0]                    avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire logic                      rxd_i,
  output logic                           txd_o,
  output logic                           sclk_o,
  output logic                           sclk_oe_n_o,
  output logic                           irq_rx_full_o,
  output logic                           irq_tx_empty_o,
  output logic                           irq_rx_err_o,
  output logic                           irq_tx_end_o
);

  function automatic logic hit(input logic [21:0] a, input logic [19:0] idx);
    return a[21:2] == idx;
  endfunction

  function automatic logic [7:0] order(input logic [7:0] b, input logic msb);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return msb ? r : b;
  endfunction

  // pclk enable spacing from the two multiplier selects
  function automatic logic [2:0] pdiv(input logic [3:0] p, input logic [3:0] c);
    logic [3:0] sh;
    sh = (p > c) ? 4'(p - c) : 4'h0;
    if (sh > 4'h3) begin
      sh = 4'h3;
    end
    return 3'((4'h1 << sh) - 4'h1);
  endfunction

  // sub-tick period: 2*(div+1)*4^cks pclk
  function automatic logic [15:0] blim(input logic [7:0] d, input logic [1:0] k);
    logic [16:0] v;
    v = (17'(d) + 17'h1) << (5'(`SUBTICK_SHIFT) + 5'({k, 1'b0}));
    return 16'(v - 17'h1);
  endfunction

  function automatic logic [31:0] rd(input logic [21:0] a,
                                     input serial_port_pkg::state_s s,
                                     input logic te_end);
    logic [31:0] r;
    r = 32'h0;
    if (hit(a, `MODULE_STOP_IDX)) begin
      r[`STOP_BIT] = s.mstp;
    end
    if (hit(a, `SYS_CLK_IDX)) begin
      r[`PCLK_SEL_MSB:`PCLK_SEL_LSB] = s.periph_clock_select;
      r[`SCLK_SEL_MSB:`SCLK_SEL_LSB] = s.system_clock_select;
    end
    if (hit(a, `RX_FULL_FLAG_IDX)) r[0] = s.ir_rx;
    if (hit(a, `TX_EMPTY_FLAG_IDX)) r[0] = s.ir_tx;
    if (hit(a, `IRQ_EN_A_IDX)) r[`IEN_A_RX] = s.ien_rx;
    if (hit(a, `IRQ_EN_B_IDX)) r[`IEN_B_TX] = s.ien_tx;
    if (hit(a, `IRQ_PRIO_IDX)) r[3:0] = s.prio;
    if (hit(a, `MODE_IDX)) r[7:0] = s.mode;
    if (hit(a, `DIVISOR_IDX)) r[7:0] = s.div;
    if (hit(a, `CONTROL_IDX)) r[7:0] = s.ctl;
    if (hit(a, `TX_DATA_IDX)) r[7:0] = s.tdr;
    if (hit(a, `RX_DATA_IDX)) r[7:0] = s.rdr;
    if (hit(a, `IF_MODE_IDX)) r[7:0] = s.ifm;
    if (hit(a, `RX_BUF_IDX)) r[`RX_BUF_BIT] = s.rxbuf;
    if (hit(a, `STATUS_IDX)) begin
      r[`STAT_TX_END] = te_end;
      r[`STAT_FRAME] = s.framing_error_flag;
      r[`STAT_OVERRUN] = s.overrun_error_flag;
    end
    return r;
  endfunction

  serial_port_pkg::state_s st;
  serial_port_pkg::state_s n;
  logic [31:0]             wd;
  logic [21:0]             ad;
  logic                    req;
  logic                    wr_acc;
  logic                    wr_tdr;
  logic                    en;
  logic                    pclk_en;
  logic                    tick;
  logic                    tx_end_flag;
  logic                    rx_in;
  logic                    rx_done;
  logic                    prio_on;

  assign wd = avs_req_i.writedata;
  assign ad = avs_req_i.address;
  assign req = avs_req_i.read | avs_req_i.write;
  assign wr_acc = avs_req_i.write & ~st.wreq;
  assign wr_tdr = wr_acc & avs_req_i.byteenable[0] & hit(ad, `TX_DATA_IDX);
  assign en = st.ctl[`CTL_TX_EN] | st.ctl[`CTL_RX_EN];
  assign pclk_en = st.pcnt == pdiv(st.periph_clock_select, st.system_clock_select); // RULE20
  assign tick = pclk_en && st.scnt == blim(st.div, st.mode[`MODE_CKS_MSB:`MODE_CKS_LSB]); // RULE9
  assign tx_end_flag = ~st.tdr_full & (st.tx_st == serial_port_pkg::TX_IDLE); // RULE11
  assign rx_in = st.rxbuf ? rxd_i : 1'b1; // RULE21
  assign rx_done = tick && st.rx_st == serial_port_pkg::RX_STOP && st.rx_tk == `TICK_LAST;
  assign prio_on = st.prio != 4'h0;

  always_comb begin
    n = st;
    // bus: one wait cycle, then one cycle with waitrequest low
    if (req && st.wreq) begin
      n.wreq = 1'b0;
      n.rdata = rd(ad, st, tx_end_flag);
    end else begin
      n.wreq = 1'b1;
    end

    // baud generator, stopped while module stopped or disabled
    n.pcnt = pclk_en ? 3'h0 : 3'(st.pcnt + 3'h1);
    if (pclk_en) begin
      n.scnt = tick ? 16'h0 : 16'(st.scnt + 16'h1);
    end
    if (!en || st.mstp) begin
      n.scnt = 16'h0;
    end

    if (wr_acc && avs_req_i.byteenable[0]) begin
      if (hit(ad, `CONTROL_IDX)) begin
        n.ctl[`CTL_TX_IE] = wd[`CTL_TX_IE];
        n.ctl[`CTL_RX_IE] = wd[`CTL_RX_IE];
        n.ctl[`CTL_END_IE] = wd[`CTL_END_IE];
        if (!en) begin
          n.ctl[`CTL_CKE_MSB:`CTL_CKE_LSB] = wd[`CTL_CKE_MSB:`CTL_CKE_LSB]; // RULE2
          n.ctl[`CTL_TX_EN] = wd[`CTL_TX_EN]; // RULE3
          n.ctl[`CTL_RX_EN] = wd[`CTL_RX_EN];
        end else if (!wd[`CTL_TX_EN] && !wd[`CTL_RX_EN]) begin
          n.ctl[`CTL_TX_EN] = 1'b0; // RULE3
          n.ctl[`CTL_RX_EN] = 1'b0;
        end
      end
      if (!en && hit(ad, `MODE_IDX)) n.mode = wd[7:0]; // RULE7
      if (!en && hit(ad, `IF_MODE_IDX)) n.ifm = wd[7:0]; // RULE7
      if (!en && hit(ad, `DIVISOR_IDX)) n.div = wd[7:0]; // RULE10
      if (wr_tdr) begin
        n.tdr = wd[7:0]; // RULE15
        n.tdr_full = 1'b1;
      end
      if (hit(ad, `STATUS_IDX)) begin
        if (!wd[`STAT_FRAME]) n.framing_error_flag = 1'b0; // RULE14
        if (!wd[`STAT_OVERRUN]) n.overrun_error_flag = 1'b0; // RULE14
      end
      if (hit(ad, `RX_FULL_FLAG_IDX) && !wd[0]) n.ir_rx = 1'b0; // RULE18
      if (hit(ad, `TX_EMPTY_FLAG_IDX) && !wd[0]) n.ir_tx = 1'b0; // RULE18
      if (hit(ad, `IRQ_EN_A_IDX)) n.ien_rx = wd[`IEN_A_RX];
      if (hit(ad, `IRQ_EN_B_IDX)) n.ien_tx = wd[`IEN_B_TX];
      if (hit(ad, `IRQ_PRIO_IDX)) n.prio = wd[3:0];
      if (hit(ad, `RX_BUF_IDX)) n.rxbuf = wd[`RX_BUF_BIT];
    end
    if (wr_acc && avs_req_i.byteenable[1] && hit(ad, `SYS_CLK_IDX)) begin
      n.periph_clock_select = wd[`PCLK_SEL_MSB:`PCLK_SEL_LSB];
    end
    if (wr_acc && avs_req_i.byteenable[3]) begin
      if (hit(ad, `SYS_CLK_IDX)) n.system_clock_select = wd[`SCLK_SEL_MSB:`SCLK_SEL_LSB];
      if (hit(ad, `MODULE_STOP_IDX)) n.mstp = wd[`STOP_BIT]; // RULE19
    end

    // empty data register on transmit enable raises the tx request
    if (!st.ctl[`CTL_TX_EN] && n.ctl[`CTL_TX_EN] && !st.tdr_full && n.ctl[`CTL_TX_IE]) begin
      n.ir_tx = 1'b1; // RULE23
    end

    // transmitter: start, 8 data, 1 stop
    if (tick && st.ctl[`CTL_TX_EN]) begin
      n.tx_tk = 4'(st.tx_tk + 4'h1);
      unique case (st.tx_st)
        serial_port_pkg::TX_IDLE: begin
          n.tx_tk = 4'h0;
          if (st.tdr_full && !wr_tdr) begin
            n.tx_sh = order(st.tdr, st.ifm[`IFM_ORDER]); // RULE8
            n.tdr_full = 1'b0;
            n.txd = 1'b0;
            n.tx_st = serial_port_pkg::TX_START;
            if (st.ctl[`CTL_TX_IE]) n.ir_tx = 1'b1; // RULE23 RULE4
          end
        end
        serial_port_pkg::TX_START: begin
          if (st.tx_tk == `TICK_LAST) begin
            n.tx_st = serial_port_pkg::TX_DATA;
            n.txd = st.tx_sh[0];
            n.tx_bit = 3'h0;
          end
        end
        serial_port_pkg::TX_DATA: begin
          if (st.tx_tk == `TICK_LAST) begin
            n.tx_sh = st.tx_sh >> 1;
            n.tx_bit = 3'(st.tx_bit + 3'h1);
            if (st.tx_bit == 3'h7) begin
              n.tx_st = serial_port_pkg::TX_STOP; // RULE6
              n.txd = 1'b1;
            end else begin
              n.txd = st.tx_sh[1];
            end
          end
        end
        serial_port_pkg::TX_STOP: begin
          if (st.tx_tk == `TICK_LAST) n.tx_st = serial_port_pkg::TX_IDLE; // RULE5
        end
        default: n.tx_st = serial_port_pkg::TX_IDLE;
      endcase
    end
    if (!st.ctl[`CTL_TX_EN] || st.mstp) begin
      n.tx_st = serial_port_pkg::TX_IDLE; // RULE19
      n.txd = 1'b1;
    end

    // receiver: start checked mid-bit, then every 16 sub-ticks
    if (tick && st.ctl[`CTL_RX_EN]) begin
      n.rx_tk = 4'(st.rx_tk + 4'h1);
      unique case (st.rx_st)
        serial_port_pkg::RX_IDLE: begin
          n.rx_tk = 4'h0;
          if (!rx_in) n.rx_st = serial_port_pkg::RX_START;
        end
        serial_port_pkg::RX_START: begin
          if (st.rx_tk == `RX_MID) begin
            n.rx_tk = 4'h0;
            n.rx_bit = 3'h0;
            n.rx_st = rx_in ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (st.rx_tk == `TICK_LAST) begin
            n.rx_sh = {rx_in, st.rx_sh[7:1]};
            n.rx_bit = 3'(st.rx_bit + 3'h1);
            if (st.rx_bit == 3'h7) n.rx_st = serial_port_pkg::RX_STOP; // RULE6
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (rx_done) begin
            n.rx_st = serial_port_pkg::RX_IDLE;
            if (!rx_in) n.framing_error_flag = 1'b1; // RULE12
            if (st.ir_rx) begin
              n.overrun_error_flag = 1'b1; // RULE13
            end else begin
              n.rdr = order(st.rx_sh, st.ifm[`IFM_ORDER]); // RULE15 RULE8
              if (st.ctl[`CTL_RX_IE]) n.ir_rx = 1'b1; // RULE23 RULE4
            end
          end
        end
        default: n.rx_st = serial_port_pkg::RX_IDLE;
      endcase
    end
    if (!st.ctl[`CTL_RX_EN] || st.mstp) begin
      n.rx_st = serial_port_pkg::RX_IDLE;
    end

    n.sclk_oe_n = st.ctl[`CTL_CKE_MSB:`CTL_CKE_LSB] == 2'b00; // RULE1
    n.sclk = st.tx_tk[3];
    n.irq[0] = prio_on & st.ien_rx & st.ir_rx; // RULE16 RULE17
    n.irq[1] = prio_on & st.ien_tx & st.ir_tx; // RULE16 RULE17
    n.irq[2] = prio_on & st.ctl[`CTL_RX_IE] & (st.framing_error_flag | st.overrun_error_flag); // RULE4
    n.irq[3] = prio_on & st.ctl[`CTL_END_IE] & tx_end_flag; // RULE4
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.wreq <= 1'b1;
      st.mstp <= `STOP_RST;
      st.periph_clock_select <= `PCLK_SEL_RST;
      st.system_clock_select <= `SCLK_SEL_RST;
      st.div <= `DIVISOR_RST;
      st.tx_st <= serial_port_pkg::TX_IDLE;
      st.rx_st <= serial_port_pkg::RX_IDLE;
      st.txd <= 1'b1;
      st.sclk_oe_n <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.wreq;
  assign txd_o = st.txd;
  assign sclk_o = st.sclk;
  assign sclk_oe_n_o = st.sclk_oe_n;
  assign irq_rx_full_o = st.irq[0];
  assign irq_tx_empty_o = st.irq[1];
  assign irq_rx_err_o = st.irq[2];
  assign irq_tx_end_o = st.irq[3];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_cke_lock;
    (wr_acc && hit(ad, `CONTROL_IDX) && en) |=> $stable(st.ctl[1:0]);
  endproperty
  a_cke_lock: assert property (p_cke_lock) else $error("clock enable changed while enabled"); // RULE2

  property p_en_pair;
    en |=> (st.ctl[5:4] == $past(st.ctl[5:4])) || (st.ctl[5:4] == 2'b00);
  endproperty
  a_en_pair: assert property (p_en_pair) else $error("enable pair changed illegally"); // RULE3

  property p_mode_lock;
    (wr_acc && hit(ad, `MODE_IDX) && en) |=> $stable(st.mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode written while enabled"); // RULE7

  property p_div_lock;
    (wr_acc && hit(ad, `DIVISOR_IDX) && en) |=> $stable(st.div);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("divisor written while enabled"); // RULE10

  // status read while a frame is on the line must show tx end low
  property p_tx_end_flag;
    (st.tx_st != serial_port_pkg::TX_IDLE && req && st.wreq && hit(ad, `STATUS_IDX))
      |=> !avs_readdata_o[`STAT_TX_END];
  endproperty
  a_tx_end_flag: assert property (p_tx_end_flag) else $error("tx end high while sending"); // RULE11

  property p_fer_cause;
    $rose(st.framing_error_flag) |-> $past(rx_done) && !$past(rx_in);
  endproperty
  a_fer_cause: assert property (p_fer_cause) else $error("framing flag without cause"); // RULE12

  property p_fer_keep;
    (st.framing_error_flag && wr_acc && hit(ad, `STATUS_IDX) && wd[`STAT_FRAME]) |=> st.framing_error_flag;
  endproperty
  a_fer_keep: assert property (p_fer_keep) else $error("writing one cleared framing flag"); // RULE14

  property p_prio_off;
    (st.prio == 4'h0) |=> (st.irq == 4'h0);
  endproperty
  a_prio_off: assert property (p_prio_off) else $error("request passed at priority zero"); // RULE16

  property p_stop_idle;
    st.mstp |=> (st.tx_st == serial_port_pkg::TX_IDLE) && txd_o ##1 txd_o;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stopped channel still sending"); // RULE19

  property p_rx_load;
    (rx_done && !st.ir_rx && st.ctl[`CTL_RX_IE])
      |=> st.ir_rx && ($past(st.ifm[`IFM_ORDER]) || (st.rdr == $past(st.rx_sh)));
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx full flag not set on load"); // RULE23

  c_tx_done: cover property ($rose(tx_end_flag));
  c_rx_char: cover property ($rose(st.ir_rx));
  c_overrun: cover property ($rose(st.overrun_error_flag));
endmodule

// file: sim/uart_master_model.sv
`timescale 1ns/1ps
// remote end of the serial line: 8n1, lsb first, fixed bit length in clocks
module uart_master_model #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  logic [7:0] rx_byte_q;
  int         rx_cnt_q;
  logic [7:0] sh;

  initial begin
    rxd_o     = 1'b1;
    rx_cnt_q  = 0;
    rx_byte_q = 8'h00;
    sh        = 8'h00;
  end

  // idle level is high, as on a pulled-up line
  task automatic send(input logic [7:0] d, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  // samples each data bit in its middle
  always begin
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      sh = {txd_i, sh[7:1]};
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    rx_byte_q = sh;
    rx_cnt_q  = rx_cnt_q + 1;
  end
endmodule

// file: sim/serial_port_tb.sv
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_port_tb;
  logic                      sys_clk_i = 1'b0;
  logic                      rst_n_i   = 1'b0;
  serial_port_pkg::bus_req_s req       = '0;
  logic [31:0]               rdata;
  logic                      wait_req;
  logic                      rxd;
  logic                      txd;
  logic                      sclk;
  logic                      sclk_oe_n;
  logic                      irq_rf;
  logic                      irq_te;
  logic                      irq_re;
  logic                      irq_tx_end_flag;
  int                        error_cnt       = 0;
  int                        samples_checked = 0;
  logic [31:0]               rv;
  int                        n;
  int                        c;

  always #5 sys_clk_i = ~sys_clk_i;

  serial_port u_serial_port (
    .sys_clk_i        (sys_clk_i),
    .rst_n_i          (rst_n_i),
    .avs_req_i        (req),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wait_req),
    .rxd_i            (rxd),
    .txd_o            (txd),
    .sclk_o           (sclk),
    .sclk_oe_n_o      (sclk_oe_n),
    .irq_rx_full_o    (irq_rf),
    .irq_tx_empty_o   (irq_te),
    .irq_rx_err_o     (irq_re),
    .irq_tx_end_o     (irq_tx_end_flag)
  );

  uart_master_model u_uart_master_model (
    .clk_i(sys_clk_i),
    .txd_i(txd),
    .rxd_o(rxd)
  );

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [19:0] idx, input logic [31:0] d);
    req.address    <= {idx, 2'b00};
    req.read       <= ~wr_en;
    req.write      <= wr_en;
    req.writedata  <= d;
    req.byteenable <= 4'hf;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      $display("MISMATCH t=%0t bus access timed out", $time);
    end
    rv = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [19:0] idx, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rv & m, exp);
  endtask

  task automatic wait_frame(input int c0);
    n = 0;
    while (u_uart_master_model.rx_cnt_q == c0 && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      $display("MISMATCH t=%0t frame never arrived", $time);
    end
    repeat (100) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    rd(`DIVISOR_IDX, 32'hffffffff, 32'h000000ff);
    rd(`SYS_CLK_IDX, 32'hffffffff, 32'h00000100);
    rd(`MODULE_STOP_IDX, 32'hffffffff, 32'h80000000);
    rd(`MODE_IDX, 32'hffffffff, 32'h0);
    rd(20'h00001, 32'hffffffff, 32'h0);
    chk(sclk_oe_n, 1'b1);
    chk(sclk, 1'b0);
    chk(txd, 1'b1);
  endtask

  // byte queued while stopped goes out only once the stop is cleared
  task automatic t_stop_and_send();
    wr(`DIVISOR_IDX, 32'h0);
    wr(`IRQ_PRIO_IDX, 32'h1);
    wr(`IRQ_EN_A_IDX, 32'h80);
    wr(`IRQ_EN_B_IDX, 32'h01);
    repeat (64) @(posedge sys_clk_i);
    wr(`CONTROL_IDX, 32'hf4);
    rd(`CONTROL_IDX, 32'hff, 32'hf4);
    wr(`TX_DATA_IDX, 32'ha5);
    rd(`TX_DATA_IDX, 32'hff, 32'ha5);
    c = u_uart_master_model.rx_cnt_q;
    repeat (300) @(posedge sys_clk_i);
    chk(u_uart_master_model.rx_cnt_q, c);
    wr(`MODULE_STOP_IDX, 32'h0);
    repeat (20) @(posedge sys_clk_i);
    rd(`STATUS_IDX, 32'h04, 32'h0);
    wait_frame(c);
    chk(u_uart_master_model.rx_byte_q, 8'ha5);
    rd(`STATUS_IDX, 32'h04, 32'h04);
    rd(`TX_EMPTY_FLAG_IDX, 32'hff, 32'h01);
    chk(irq_tx_end_flag, 1'b1);
    chk(irq_te, 1'b1);
    chk(sclk_oe_n, 1'b1);
  endtask

  task automatic t_receive();
    u_uart_master_model.send(8'h3c, 1'b1);
    repeat (64) @(posedge sys_clk_i);
    rd(`RX_FULL_FLAG_IDX, 32'hff, 32'h0);
    wr(`RX_BUF_IDX, 32'h02);
    u_uart_master_model.send(8'h3c, 1'b1);
    repeat (64) @(posedge sys_clk_i);
    rd(`RX_DATA_IDX, 32'hff, 32'h3c);
    rd(`RX_FULL_FLAG_IDX, 32'hff, 32'h01);
    chk(irq_rf, 1'b1);
    wr(`RX_FULL_FLAG_IDX, 32'h0);
    rd(`RX_FULL_FLAG_IDX, 32'hff, 32'h0);
  endtask

  task automatic t_lockout();
    wr(`DIVISOR_IDX, 32'h05);
    rd(`DIVISOR_IDX, 32'hff, 32'h0);
    wr(`MODE_IDX, 32'h03);
    rd(`MODE_IDX, 32'hff, 32'h0);
    wr(`IF_MODE_IDX, 32'h08);
    rd(`IF_MODE_IDX, 32'hff, 32'h0);
    wr(`CONTROL_IDX, 32'he5);
    rd(`CONTROL_IDX, 32'hff, 32'hf4);
    chk(sclk_oe_n, 1'b1);
  endtask

  task automatic t_errors();
    u_uart_master_model.send(8'h11, 1'b1);
    u_uart_master_model.send(8'h22, 1'b1);
    repeat (64) @(posedge sys_clk_i);
    rd(`STATUS_IDX, 32'h30, 32'h20);
    rd(`RX_DATA_IDX, 32'hff, 32'h11);
    chk(irq_re, 1'b1);
    wr(`STATUS_IDX, 32'hff);
    rd(`STATUS_IDX, 32'h30, 32'h20);
    wr(`STATUS_IDX, 32'h0);
    rd(`STATUS_IDX, 32'h30, 32'h0);
    wr(`RX_FULL_FLAG_IDX, 32'h0);
    u_uart_master_model.send(8'h5a, 1'b0);
    repeat (40) @(posedge sys_clk_i);
    rd(`STATUS_IDX, 32'h10, 32'h10);
    rd(`RX_DATA_IDX, 32'hff, 32'h5a);
    wr(`CONTROL_IDX, 32'hb4);
    repeat (3) @(posedge sys_clk_i);
    chk(irq_re, 1'b0);
    wr(`IRQ_PRIO_IDX, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    chk({irq_rf, irq_te, irq_tx_end_flag}, 3'b000);
  endtask

  task automatic t_order();
    wr(`CONTROL_IDX, 32'h0);
    rd(`CONTROL_IDX, 32'h30, 32'h0);
    wr(`IF_MODE_IDX, 32'h08);
    wr(`CONTROL_IDX, 32'h20);
    c = u_uart_master_model.rx_cnt_q;
    wr(`TX_DATA_IDX, 32'h01);
    wait_frame(c);
    chk(u_uart_master_model.rx_byte_q, 8'h80);
    wr(`CONTROL_IDX, 32'h0);
  endtask

  // divisor 31h: start bit length in clocks
  task automatic t_baud();
    wr(`IF_MODE_IDX, 32'h0);
    wr(`DIVISOR_IDX, 32'h31);
    rd(`DIVISOR_IDX, 32'hff, 32'h31);
    repeat (3200) @(posedge sys_clk_i);
    wr(`CONTROL_IDX, 32'h20);
    wr(`TX_DATA_IDX, 32'hff);
    n = 0;
    while (txd !== 1'b0 && n < 8000) begin
      @(posedge sys_clk_i);
      n++;
    end
    n = 0;
    while (txd === 1'b0 && n < 8000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(n, 3200);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_stop_and_send();
    t_receive();
    t_lockout();
    t_errors();
    t_order();
    t_baud();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule
